// ---- dv/dcpi_ctrl_model.sv ----
// Memory controller model driving the command pins
`timescale 1ns/100ps
module dcpi_ctrl_model
    import dcpi_pkg::*;
(
    input wire logic ck_i,
    output logic cke_o,
    output logic [3:0] code_o,
    output logic [BANK_W-1:0] bank_select_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic term_control_o
);
    initial begin
        cke_o = 1'b0;
        code_o = 4'hf;
        bank_select_o = 3'h0;
        addr_o = 16'h0000;
        term_control_o = 1'b0;
    end
    // Launch after a falling edge so pins are settled at the rising edge
    task automatic send(input logic [3:0] code, input logic [2:0] ba, input logic [15:0] a,
        input logic cke);
        @(negedge ck_i);
        code_o = code;
        bank_select_o = ba;
        addr_o = a;
        cke_o = cke;
        @(negedge ck_i);
        code_o = 4'hf;
        // Turned-over address so a stale value cannot pose as a command
        addr_o = ~a;
        bank_select_o = ~ba;
    endtask
    // Unsynced change only for wake-up with the clock stopped
    task automatic set_pin(input logic cke, input logic term, input logic sync);
        if (sync)
            @(negedge ck_i);
        cke_o = cke;
        term_control_o = term;
    endtask
endmodule

// ---- dv/dcpi_top_monitor.sv ----
// Assertion checker bound to the command pin interface top
`timescale 1ns/100ps
module dcpi_top_monitor
    import dcpi_pkg::*;
#(
    parameter bit WORD_WIDE = 1'b0,
    parameter int BYTES = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ck_i,
    input wire logic mem_rst_b_i,
    input wire logic cke_i,
    input wire logic wdata_valid_i,
    input wire logic [BYTES-1:0] write_mask_i,
    input wire logic clocks_run_o,
    input wire logic cmd_buf_en_o,
    input wire logic term_buf_en_o,
    input wire logic out_drv_en_o,
    input wire logic cmd_valid_o,
    input wire dcpi_cmd_t cmd_o,
    input wire logic [ADDR_W-1:0] mode_reg_one_o,
    input wire logic [ADDR_W-1:0] mode_reg_two_o,
    input wire logic term_enable_o,
    input wire logic term_strobe_en_o,
    input wire logic [BYTES-1:0] wdata_keep_o,
    input wire logic wdata_valid_o
);
    // System side also sits in reset while the pin reset is low
    a_pulse_single: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) cmd_valid_o |=> !cmd_valid_o)
        else $error("command pulse too long");
    a_cmd_steady: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) !cmd_valid_o |-> $stable(cmd_o))
        else $error("command changed without pulse");
    a_mr_one_load: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) cmd_valid_o && cmd_o.kind == DCPI_CMD_MODE_SET
        && cmd_o.bank_select == SEL_MODE_REG_ONE |-> mode_reg_one_o == cmd_o.addr)
        else $error("mode register one not loaded");
    a_mr_two_load: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) cmd_valid_o && cmd_o.kind == DCPI_CMD_MODE_SET
        && cmd_o.bank_select == SEL_MODE_REG_TWO |-> mode_reg_two_o == cmd_o.addr)
        else $error("mode register two not loaded");
    a_keep_mask: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) wdata_valid_i |=> wdata_valid_o
        && wdata_keep_o == ((!WORD_WIDE && $past(mode_reg_one_o[TERM_STROBE_BIT]))
        ? {BYTES{1'b1}} : ~$past(write_mask_i))) else $error("write keep wrong");
    a_term_gate: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) term_enable_o |-> |($past(mode_reg_one_o)
        & MR1_TERM_MASK) || |($past(mode_reg_two_o) & MR2_TERM_MASK))
        else $error("termination on while disabled");
    a_strobe_gate: assert property (@(posedge clk_i)
        disable iff (!rst_b_i || !mem_rst_b_i) term_strobe_en_o |-> !WORD_WIDE
        && term_enable_o && $past(mode_reg_one_o[TERM_STROBE_BIT]))
        else $error("strobe termination unexpected");
    a_bufs_follow: assert property (@(posedge ck_i) disable iff (!mem_rst_b_i)
        cmd_buf_en_o == clocks_run_o && out_drv_en_o == clocks_run_o)
        else $error("buffers disagree with clocks");
    a_sr_bufs_off: assert property (@(posedge ck_i) disable iff (!mem_rst_b_i)
        !term_buf_en_o |-> !cmd_buf_en_o && !clocks_run_o) else $error("buffer on in refresh");
    a_cke_stops: assert property (@(posedge ck_i) disable iff (!mem_rst_b_i)
        !cke_i [*3] |=> !clocks_run_o) else $error("clocks run with enable low");
endmodule

bind dcpi_top dcpi_top_monitor #(.WORD_WIDE(WORD_WIDE), .BYTES(BYTES)) u_mon (
    .clk_i, .rst_b_i, .ck_i, .mem_rst_b_i, .cke_i, .wdata_valid_i, .write_mask_i,
    .clocks_run_o, .cmd_buf_en_o, .term_buf_en_o, .out_drv_en_o, .cmd_valid_o, .cmd_o,
    .mode_reg_one_o, .mode_reg_two_o, .term_enable_o, .term_strobe_en_o, .wdata_keep_o,
    .wdata_valid_o);

// ---- dv/tb_dcpi_top.sv ----
// Self-checking bench for the command pin interface
`timescale 1ns/100ps
module tb_dcpi_top
    import dcpi_pkg::*;
;
    typedef struct packed {
        logic [3:0] code;
        logic [2:0] ba;
        logic [15:0] a;
        dcpi_cmd_kind_t kind;
        logic [15:0] ea;
        logic [2:0] fl;
        logic [7:0] open;
    } dcpi_row_t;
    logic clk_i = 1'b0;
    logic ck_i = 1'b0;
    logic ck_run = 1'b1;
    logic rst_b_i = 1'b0;
    logic mem_rst_b_i = 1'b0;
    logic cke_i, term_control_i, wdata_valid_i, wdata_valid_o, clocks_run_o, cmd_buf_en_o;
    logic term_buf_en_o, out_drv_en_o, cmd_valid_o, self_refresh_o, term_enable_o;
    logic term_strobe_en_o;
    logic [3:0] code;
    logic [2:0] bank_select_i;
    logic [15:0] addr_i, mode_reg_one_o, mode_reg_two_o;
    logic [7:0] wdata_i, wdata_o, bank_open_o;
    logic [0:0] write_mask_i, wdata_keep_o;
    dcpi_cmd_t cmd_o, got;
    dcpi_pwr_t power_state_o;
    dcpi_row_t r;
    int bad_count = 0;
    int tests_run = 0;
    dcpi_row_t rows [12] = '{
        '{4'h3, 3'h2, 16'h1234, DCPI_CMD_ACTIVATE, 16'h1234, 3'b000, 8'h04},
        '{4'h3, 3'h5, 16'hbeef, DCPI_CMD_ACTIVATE, 16'hbeef, 3'b000, 8'h24},
        '{4'h3, 3'h7, 16'h0001, DCPI_CMD_ACTIVATE, 16'h0001, 3'b000, 8'ha4},
        '{4'hb, 3'h1, 16'h0002, DCPI_CMD_NOP, 16'h0000, 3'b000, 8'ha4},
        '{4'h4, 3'h2, 16'h13ff, DCPI_CMD_WRITE, 16'h03ff, 3'b010, 8'ha4},
        '{4'h5, 3'h2, 16'h0555, DCPI_CMD_READ, 16'h0155, 3'b100, 8'ha0},
        '{4'h2, 3'h5, 16'h0000, DCPI_CMD_PRECHARGE, 16'h0000, 3'b000, 8'h80},
        '{4'h2, 3'h1, 16'h0400, DCPI_CMD_PRECHARGE, 16'h0000, 3'b001, 8'h00},
        '{4'h1, 3'h0, 16'h0000, DCPI_CMD_REFRESH, 16'h0000, 3'b000, 8'h00},
        '{4'h0, 3'h1, 16'h0244, DCPI_CMD_MODE_SET, 16'h0244, 3'b000, 8'h00},
        '{4'h0, 3'h2, 16'h0600, DCPI_CMD_MODE_SET, 16'h0600, 3'b000, 8'h00},
        '{4'h7, 3'h0, 16'h0000, DCPI_CMD_NOP, 16'h0000, 3'b000, 8'h00}};
    always #5 clk_i = ~clk_i;
    // Offset start keeps the two clocks from sharing edges
    initial begin
        #2.3;
        forever #15 ck_i = ck_run ? ~ck_i : 1'b0;
    end
    logic cs_b_i, ras_b_i, cas_b_i, we_b_i;
    assign {cs_b_i, ras_b_i, cas_b_i, we_b_i} = code;
    dcpi_ctrl_model ctrl (.ck_i, .cke_o(cke_i), .code_o(code), .bank_select_o(bank_select_i),
        .addr_o(addr_i), .term_control_o(term_control_i));
    dcpi_top #(.WORD_WIDE(1'b0), .BYTES(1)) DUT (.clk_i, .rst_b_i, .ck_i, .mem_rst_b_i,
        .cke_i, .cs_b_i, .ras_b_i, .cas_b_i, .we_b_i, .bank_select_i, .addr_i,
        .term_control_i, .wdata_i, .wdata_valid_i, .write_mask_i, .clocks_run_o,
        .cmd_buf_en_o, .term_buf_en_o, .out_drv_en_o, .bank_open_o, .cmd_valid_o, .cmd_o,
        .power_state_o, .self_refresh_o, .mode_reg_one_o, .mode_reg_two_o, .term_enable_o,
        .term_strobe_en_o, .wdata_o, .wdata_keep_o, .wdata_valid_o);
    task automatic summarize;
        $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for the command pulse; a missing pulse ends the run
    task automatic grab(input logic fire);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 30 && !seen; i++) begin
            @(posedge clk_i);
            #1;
            if (cmd_valid_o === 1'b1) begin
                seen = 1'b1;
                got = cmd_o;
            end
        end
        chk(32'(seen), 32'(fire));
        if (fire && !seen)
            summarize();
    endtask
    task automatic term_chk(input logic [15:0] mr1, input logic [15:0] mr2, input logic [1:0] e);
        ctrl.send(CODE_MODE_SET, SEL_MODE_REG_ONE, mr1, 1'b1);
        grab(1'b1);
        ctrl.send(CODE_MODE_SET, SEL_MODE_REG_TWO, mr2, 1'b1);
        grab(1'b1);
        ctrl.set_pin(1'b1, 1'b1, 1'b1);
        repeat (20) @(negedge clk_i);
        chk(32'({term_enable_o, term_strobe_en_o}), 32'(e));
        ctrl.set_pin(1'b1, 1'b0, 1'b1);
        repeat (20) @(negedge clk_i);
    endtask
    task automatic wr(input logic [1:0] m, input logic [1:0] k);
        @(negedge clk_i);
        wdata_valid_i = 1'b1;
        wdata_i = 8'h5a;
        write_mask_i = m[1];
        @(negedge clk_i);
        chk(32'({wdata_valid_o, wdata_keep_o}), 32'({1'b1, k[1]}));
        wdata_i = 8'ha5;
        write_mask_i = m[0];
        @(negedge clk_i);
        chk(32'({wdata_keep_o, wdata_o}), 32'({k[0], 8'ha5}));
        wdata_valid_i = 1'b0;
    endtask
    task automatic pwr(input logic cke, input dcpi_pwr_t st);
        ctrl.set_pin(cke, 1'b0, 1'b1);
        repeat (20) @(negedge clk_i);
        chk(32'(power_state_o), 32'(st));
    endtask
    initial begin
        wdata_i = 8'h00;
        wdata_valid_i = 1'b0;
        write_mask_i = 1'b0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        mem_rst_b_i = 1'b1;
        pwr(1'b0, DCPI_PWR_PD_PRE);
        pwr(1'b1, DCPI_PWR_RUN);
        foreach (rows[i]) begin
            r = rows[i];
            ctrl.send(r.code, r.ba, r.a, 1'b1);
            grab(r.kind != DCPI_CMD_NOP);
            if (r.kind != DCPI_CMD_NOP) begin
                chk(32'({got.kind, got.bank_select}), 32'({r.kind, r.ba}));
                if (r.kind != DCPI_CMD_PRECHARGE)
                    chk(32'(got.addr), 32'(r.ea));
                if (r.kind inside {DCPI_CMD_READ, DCPI_CMD_WRITE})
                    chk(32'({got.auto_close_flag, got.burst_shorten_n}), 32'(r.fl[2:1]));
                if (r.kind == DCPI_CMD_PRECHARGE)
                    chk(32'(got.all_banks), 32'(r.fl[0]));
            end
            chk(32'(bank_open_o), 32'(r.open));
            $display("Row %0d done", i);
        end
        chk(32'({mode_reg_one_o, mode_reg_two_o}), 32'h02440600);
        term_chk(16'h0004, 16'h0000, 2'b10);
        // Byte-wide part, so the strobe bit may be set
        term_chk(16'h0840, 16'h0000, 2'b11);
        wr(2'b10, 2'b11);
        term_chk(16'h0000, 16'h0200, 2'b10);
        wr(2'b10, 2'b01);
        term_chk(16'h0800, 16'h0000, 2'b00);
        $display("Termination and mask tests done");
        pwr(1'b0, DCPI_PWR_PD_PRE);
        chk(32'({clocks_run_o, term_buf_en_o}), 32'h1);
        ctrl.send(CODE_ACTIVATE, 3'h3, 16'h0000, 1'b0);
        grab(1'b0);
        pwr(1'b1, DCPI_PWR_RUN);
        ctrl.send(CODE_ACTIVATE, 3'h3, 16'h0000, 1'b1);
        grab(1'b1);
        pwr(1'b0, DCPI_PWR_PD_ACT);
        pwr(1'b1, DCPI_PWR_RUN);
        ctrl.send(CODE_PRECHARGE, 3'h0, 16'h0400, 1'b1);
        grab(1'b1);
        ctrl.send(CODE_REFRESH, 3'h0, 16'h0000, 1'b0);
        repeat (20) @(negedge clk_i);
        chk(32'({power_state_o, self_refresh_o, term_buf_en_o}), 32'h22);
        // Wake with the link clock stopped
        ck_run = 1'b0;
        repeat (4) @(negedge clk_i);
        ctrl.set_pin(1'b1, 1'b0, 1'b0);
        repeat (10) @(negedge clk_i);
        chk(32'(self_refresh_o), 32'h0);
        ck_run = 1'b1;
        pwr(1'b1, DCPI_PWR_RUN);
        ctrl.send(CODE_ACTIVATE, 3'h6, 16'h0000, 1'b1);
        grab(1'b1);
        @(negedge clk_i);
        mem_rst_b_i = 1'b0;
        #1;
        chk(32'({bank_open_o, clocks_run_o}), 32'h0);
        repeat (10) @(negedge clk_i);
        chk(32'(power_state_o), 32'(DCPI_PWR_PD_PRE));
        $display("Power and reset tests done");
        summarize();
    end
endmodule

// ---- hw/dcpi_pin_sampler.sv ----
// Link-clock pin capture and command decode
`timescale 1ns/100ps
module dcpi_pin_sampler
    import dcpi_pkg::*;
#(
    parameter int ROW_W = ROW_W_BYTE
) (
    input wire logic ck_i,
    input wire logic mem_rst_b_i,
    input wire logic cmd_buf_en_i,
    input wire logic term_buf_en_i,
    input wire logic cke_i,
    input wire logic cs_b_i,
    input wire logic ras_b_i,
    input wire logic cas_b_i,
    input wire logic we_b_i,
    input wire logic [BANK_W-1:0] bank_select_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic term_control_i,
    output logic cke_now_o,
    output logic cke_prev_o,
    output logic term_control_o,
    output dcpi_cmd_t cmd_o
);
    logic [3:0] code_q;
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic cke_q;
    logic cke_prev_q;
    logic term_q;
    logic [ADDR_W-1:0] row_mask;

    assign row_mask = ADDR_W'((32'h1 << ROW_W) - 32'h1);

    // Sampled on the rising edge of the true clock
    always_ff @(posedge ck_i or negedge mem_rst_b_i) begin
        if (!mem_rst_b_i) begin
            cke_q <= 1'b0;
            cke_prev_q <= 1'b0;
        end else begin
            cke_q <= cke_i;
            cke_prev_q <= cke_q;
        end
    end

    // A disabled buffer reads as deselect, so nothing decodes
    always_ff @(posedge ck_i or negedge mem_rst_b_i) begin
        if (!mem_rst_b_i) begin
            code_q <= 4'hf;
            bank_q <= '0;
            addr_q <= '0;
        end else if (cmd_buf_en_i) begin
            code_q <= {cs_b_i, ras_b_i, cas_b_i, we_b_i};
            bank_q <= bank_select_i;
            addr_q <= addr_i;
        end else begin
            code_q <= 4'hf;
        end
    end

    always_ff @(posedge ck_i or negedge mem_rst_b_i) begin
        if (!mem_rst_b_i) begin
            term_q <= 1'b0;
        end else begin
            term_q <= term_control_i & term_buf_en_i;
        end
    end

    always_comb begin
        cmd_o = '0;
        cmd_o.bank_select = bank_q;
        cmd_o.auto_close_flag = addr_q[AUTO_CLOSE_BIT];
        cmd_o.burst_shorten_n = addr_q[BURST_SHORTEN_BIT];
        case (code_q)
            CODE_ACTIVATE: begin
                cmd_o.kind = DCPI_CMD_ACTIVATE;
                cmd_o.addr = addr_q & row_mask;
            end
            CODE_READ: begin
                cmd_o.kind = DCPI_CMD_READ;
                cmd_o.addr = ADDR_W'(addr_q[COL_W-1:0]);
            end
            CODE_WRITE: begin
                cmd_o.kind = DCPI_CMD_WRITE;
                cmd_o.addr = ADDR_W'(addr_q[COL_W-1:0]);
            end
            CODE_PRECHARGE: begin
                cmd_o.kind = DCPI_CMD_PRECHARGE;
                cmd_o.all_banks = addr_q[AUTO_CLOSE_BIT];
            end
            CODE_REFRESH: begin
                cmd_o.kind = DCPI_CMD_REFRESH;
            end
            CODE_MODE_SET: begin
                cmd_o.kind = DCPI_CMD_MODE_SET;
                cmd_o.addr = addr_q;
            end
            default: begin
                cmd_o.kind = DCPI_CMD_NOP;
            end
        endcase
    end

    assign cke_now_o = cke_q;
    assign cke_prev_o = cke_prev_q;
    assign term_control_o = term_q;
endmodule

// ---- hw/dcpi_top.sv ----
// DDR3 command pin interface: power control, bank tracking and command hand-off
`timescale 1ns/100ps
module dcpi_top
    import dcpi_pkg::*;
#(
    parameter bit WORD_WIDE = 1'b0,
    parameter int BYTES = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ck_i,
    input wire logic mem_rst_b_i,
    input wire logic cke_i,
    input wire logic cs_b_i,
    input wire logic ras_b_i,
    input wire logic cas_b_i,
    input wire logic we_b_i,
    input wire logic [BANK_W-1:0] bank_select_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic term_control_i,
    input wire logic [8*BYTES-1:0] wdata_i,
    input wire logic wdata_valid_i,
    input wire logic [BYTES-1:0] write_mask_i,
    output logic clocks_run_o,
    output logic cmd_buf_en_o,
    output logic term_buf_en_o,
    output logic out_drv_en_o,
    output logic [NUM_BANKS-1:0] bank_open_o,
    output logic cmd_valid_o,
    output dcpi_cmd_t cmd_o,
    output dcpi_pwr_t power_state_o,
    output logic self_refresh_o,
    output logic [ADDR_W-1:0] mode_reg_one_o,
    output logic [ADDR_W-1:0] mode_reg_two_o,
    output logic term_enable_o,
    output logic term_strobe_en_o,
    output logic [8*BYTES-1:0] wdata_o,
    output logic [BYTES-1:0] wdata_keep_o,
    output logic wdata_valid_o
);
    localparam int ROW_W = WORD_WIDE ? ROW_W_WORD : ROW_W_BYTE;

    // ---- Link-clock domain ----
    dcpi_pwr_t pwr_q;
    dcpi_pwr_t pwr_d;
    logic cke_now;
    logic cke_prev;
    logic term_ck;
    dcpi_cmd_t dec_cmd;
    logic cmd_take;
    logic [NUM_BANKS-1:0] open_q;
    logic [NUM_BANKS-1:0] open_d;
    dcpi_cmd_t hold_q;
    logic req_tgl_q;
    logic run_q;
    logic cmd_buf_q;
    logic term_buf_q;
    logic [SYNC_STAGES-1:0] link_rst_q;
    logic link_rst_b;

    // Pin reset enters at once but leaves on a link edge, so no flop sees a torn release
    always_ff @(posedge ck_i or negedge mem_rst_b_i) begin
        if (!mem_rst_b_i) begin
            link_rst_q <= '0;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b1};
        end
    end

    assign link_rst_b = link_rst_q[1];

    dcpi_pin_sampler #(
        .ROW_W(ROW_W)
    ) u_sampler (
        .ck_i(ck_i),
        .mem_rst_b_i(link_rst_b),
        .cmd_buf_en_i(cmd_buf_q),
        .term_buf_en_i(term_buf_q),
        .cke_i(cke_i),
        .cs_b_i(cs_b_i),
        .ras_b_i(ras_b_i),
        .cas_b_i(cas_b_i),
        .we_b_i(we_b_i),
        .bank_select_i(bank_select_i),
        .addr_i(addr_i),
        .term_control_i(term_control_i),
        .cke_now_o(cke_now),
        .cke_prev_o(cke_prev),
        .term_control_o(term_ck),
        .cmd_o(dec_cmd)
    );

    // Commands count only with clock enable high on this and the previous edge
    assign cmd_take = (pwr_q == DCPI_PWR_RUN) && cke_now && cke_prev
                      && (dec_cmd.kind != DCPI_CMD_NOP);

    // Power state follows the sampled clock enable
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            DCPI_PWR_RUN: begin
                if (cke_prev && !cke_now) begin
                    if (dec_cmd.kind == DCPI_CMD_REFRESH && open_q == '0) begin
                        pwr_d = DCPI_PWR_SELF_REF;
                    end else if (open_q != '0) begin
                        pwr_d = DCPI_PWR_PD_ACT;
                    end else begin
                        pwr_d = DCPI_PWR_PD_PRE;
                    end
                end
            end
            DCPI_PWR_PD_PRE, DCPI_PWR_PD_ACT: begin
                if (cke_now) begin
                    pwr_d = DCPI_PWR_RUN;
                end
            end
            DCPI_PWR_SELF_REF: begin
                // The clock may only restart once the wake is already seen
                if (cke_now) begin
                    pwr_d = DCPI_PWR_RUN;
                end
            end
            default: begin
                pwr_d = DCPI_PWR_RUN;
            end
        endcase
    end

    // Pin reset acts without the clock
    always_ff @(posedge ck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            pwr_q <= DCPI_PWR_PD_PRE;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // Gate clocks, drivers and buffers by state
    always_ff @(posedge ck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            run_q <= 1'b0;
            cmd_buf_q <= 1'b0;
            term_buf_q <= 1'b0;
        end else begin
            run_q <= (pwr_d == DCPI_PWR_RUN);
            cmd_buf_q <= (pwr_d == DCPI_PWR_RUN);
            term_buf_q <= (pwr_d != DCPI_PWR_SELF_REF);
        end
    end

    // Per-bank row tracking
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        always_comb begin
            open_d[b] = open_q[b];
            if (cmd_take) begin
                case (dec_cmd.kind)
                    DCPI_CMD_ACTIVATE: begin
                        if (dec_cmd.bank_select == BANK_W'(b)) begin
                            open_d[b] = 1'b1;
                        end
                    end
                    DCPI_CMD_READ, DCPI_CMD_WRITE: begin
                        if (dec_cmd.bank_select == BANK_W'(b) && dec_cmd.auto_close_flag) begin
                            open_d[b] = 1'b0;
                        end
                    end
                    DCPI_CMD_PRECHARGE: begin
                        if (dec_cmd.all_banks || dec_cmd.bank_select == BANK_W'(b)) begin
                            open_d[b] = 1'b0;
                        end
                    end
                    default: begin
                        open_d[b] = open_q[b];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            open_q <= '0;
        end else begin
            open_q <= open_d;
        end
    end

    // Payload is held until the next command; the toggle marks a new one
    always_ff @(posedge ck_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            hold_q <= '0;
            req_tgl_q <= 1'b0;
        end else if (cmd_take) begin
            hold_q <= dec_cmd;
            req_tgl_q <= ~req_tgl_q;
        end
    end

    assign clocks_run_o = run_q;
    assign out_drv_en_o = run_q;
    assign cmd_buf_en_o = cmd_buf_q;
    assign term_buf_en_o = term_buf_q;
    assign bank_open_o = open_q;

    // ---- System clock domain ----
    logic [SYNC_STAGES-1:0] rst_sync_q;
    logic rst_ok;
    logic [SYNC_STAGES-1:0] tgl_sync_q;
    logic tgl_seen_q;
    logic [SYNC_STAGES-1:0] cke_sync_q;
    logic [SYNC_STAGES-1:0] term_sync_q;
    logic [3:0] pwr_s1_q;
    logic [3:0] pwr_s2_q;
    logic [3:0] pwr_s3_q;
    logic [3:0] pwr_shown_q;
    logic cmd_valid_q;
    dcpi_cmd_t cmd_q;
    logic [ADDR_W-1:0] mr1_q;
    logic [ADDR_W-1:0] mr2_q;
    logic term_on;
    logic strobe_mode;
    logic term_en_q;
    logic term_strobe_q;
    logic [8*BYTES-1:0] wdata_q;
    logic [BYTES-1:0] keep_q;
    logic wvalid_q;

    always_ff @(posedge clk_i) begin
        rst_sync_q <= {rst_sync_q[0], mem_rst_b_i};
        tgl_sync_q <= {tgl_sync_q[0], req_tgl_q};
        cke_sync_q <= {cke_sync_q[0], cke_i};
        term_sync_q <= {term_sync_q[0], term_ck};
        pwr_s1_q <= pwr_q;
        pwr_s2_q <= pwr_s1_q;
        pwr_s3_q <= pwr_s2_q;
    end

    // A one-hot change can be caught half-way; show a state only once two samples agree
    always_ff @(posedge clk_i) begin
        if (pwr_s3_q == pwr_s2_q) begin
            pwr_shown_q <= pwr_s3_q;
        end
    end

    assign rst_ok = rst_b_i & rst_sync_q[1];

    // Edge of the toggle hands over a command; hold_q is stable by then
    always_ff @(posedge clk_i) begin
        if (!rst_ok) begin
            tgl_seen_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            tgl_seen_q <= tgl_sync_q[1];
            cmd_valid_q <= tgl_sync_q[1] ^ tgl_seen_q;
            if (tgl_sync_q[1] ^ tgl_seen_q) begin
                cmd_q <= hold_q;
            end
        end
    end

    // Mode set writes the register named by bank select
    always_ff @(posedge clk_i) begin
        if (!rst_ok) begin
            mr1_q <= MODE_REG_RST;
            mr2_q <= MODE_REG_RST;
        end else if ((tgl_sync_q[1] ^ tgl_seen_q) && hold_q.kind == DCPI_CMD_MODE_SET) begin
            if (hold_q.bank_select == SEL_MODE_REG_ONE) begin
                mr1_q <= hold_q.addr;
            end
            if (hold_q.bank_select == SEL_MODE_REG_TWO) begin
                mr2_q <= hold_q.addr;
            end
        end
    end

    // Word-wide parts never use the strobe mode
    assign strobe_mode = !WORD_WIDE && mr1_q[TERM_STROBE_BIT];
    // Both registers off means the control pin is ignored
    assign term_on = ((mr1_q & MR1_TERM_MASK) != '0) || ((mr2_q & MR2_TERM_MASK) != '0);

    always_ff @(posedge clk_i) begin
        if (!rst_ok) begin
            term_en_q <= 1'b0;
            term_strobe_q <= 1'b0;
        end else begin
            term_en_q <= term_sync_q[1] && term_on;
            term_strobe_q <= term_sync_q[1] && term_on && strobe_mode;
        end
    end

    // Mask samples come from same-clock strobe capture
    for (genvar i = 0; i < BYTES; i++) begin : g_mask
        always_ff @(posedge clk_i) begin
            if (!rst_ok) begin
                wdata_q[8*i +: 8] <= 8'h00;
                keep_q[i] <= 1'b0;
            end else if (wdata_valid_i) begin
                wdata_q[8*i +: 8] <= wdata_i[8*i +: 8];
                keep_q[i] <= !(write_mask_i[i] && !strobe_mode);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_ok) begin
            wvalid_q <= 1'b0;
        end else begin
            wvalid_q <= wdata_valid_i;
        end
    end

    assign cmd_valid_o = cmd_valid_q;
    assign cmd_o = cmd_q;
    assign power_state_o = dcpi_pwr_t'(pwr_shown_q);
    // Wake is seen without the link clock
    assign self_refresh_o = (pwr_shown_q == DCPI_PWR_SELF_REF) && !cke_sync_q[1];
    assign mode_reg_one_o = mr1_q;
    assign mode_reg_two_o = mr2_q;
    assign term_enable_o = term_en_q;
    assign term_strobe_en_o = term_strobe_q;
    assign wdata_o = wdata_q;
    assign wdata_keep_o = keep_q;
    assign wdata_valid_o = wvalid_q;
endmodule

// ---- inc/dcpi_pkg.sv ----
// Shared constants and types for the DDR3 command pin interface
package dcpi_pkg;
    localparam int ADDR_W = 16;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int ROW_W_BYTE = 16;
    localparam int ROW_W_WORD = 15;
    localparam int COL_W = 10;
    localparam int AUTO_CLOSE_BIT = 10;
    localparam int BURST_SHORTEN_BIT = 12;
    localparam int TERM_STROBE_BIT = 11;
    localparam logic [ADDR_W-1:0] MR1_TERM_MASK = 16'h0244;
    localparam logic [ADDR_W-1:0] MR2_TERM_MASK = 16'h0600;
    localparam logic [ADDR_W-1:0] MODE_REG_RST = 16'h0000;
    localparam logic [BANK_W-1:0] SEL_MODE_REG_ONE = 3'h1;
    localparam logic [BANK_W-1:0] SEL_MODE_REG_TWO = 3'h2;
    localparam int SYNC_STAGES = 2;

    // Command code as {cs_b, ras_b, cas_b, we_b}
    localparam logic [3:0] CODE_MODE_SET = 4'h0;
    localparam logic [3:0] CODE_REFRESH = 4'h1;
    localparam logic [3:0] CODE_PRECHARGE = 4'h2;
    localparam logic [3:0] CODE_ACTIVATE = 4'h3;
    localparam logic [3:0] CODE_WRITE = 4'h4;
    localparam logic [3:0] CODE_READ = 4'h5;

    typedef enum logic [2:0] {
        DCPI_CMD_NOP = 3'h0,
        DCPI_CMD_ACTIVATE = 3'h1,
        DCPI_CMD_READ = 3'h2,
        DCPI_CMD_WRITE = 3'h3,
        DCPI_CMD_PRECHARGE = 3'h4,
        DCPI_CMD_REFRESH = 3'h5,
        DCPI_CMD_MODE_SET = 3'h6
    } dcpi_cmd_kind_t;

    typedef enum logic [3:0] {
        DCPI_PWR_RUN = 4'b0001,
        DCPI_PWR_PD_PRE = 4'b0010,
        DCPI_PWR_PD_ACT = 4'b0100,
        DCPI_PWR_SELF_REF = 4'b1000
    } dcpi_pwr_t;

    // Address field is row on activate, column on read/write, op-code on mode set
    typedef struct packed {
        dcpi_cmd_kind_t kind;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] addr;
        logic auto_close_flag;
        logic burst_shorten_n;
        logic all_banks;
    } dcpi_cmd_t;
endpackage
